// *** testbench/cpu_movx_model.sv ***
// behavioural cpu core issuing movx writes
`timescale 1ns/1ps
module cpu_movx_model (
    input wire logic clk,
    input wire logic movx_ready,
    output flash_seq_pkg::movx_wr_s movx
);
    initial movx = '0;

    // one write, held until taken, then the lines wander
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        movx <= {1'b1, a, d};
        do
            @(posedge clk);
        while (!movx_ready);
        movx <= {1'b0, ~a, ~d};
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the flash byte write sequencer
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic irq_pending = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, movx_ready, flash_req, irq_deliver;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    flash_seq_pkg::movx_wr_s movx;
    flash_seq_pkg::on_chip_data_memory_wr_s on_chip_data_memory;
    flash_seq_pkg::flash_cmd_s flash_cmd;
    flash_seq_pkg::flash_cmd_s fl_c;
    flash_seq_pkg::on_chip_data_memory_wr_s xr_c;
    int fl_n = 0;
    int xr_n = 0;
    int irq_lo = 0;
    int err_total = 0;
    int cmp_count = 0;

    flash_byte_write_sequencer #(.OP_CYCLES(2)) dut (.*);
    cpu_movx_model cpu (.clk, .movx_ready, .movx);

    always #12.5 clk = ~clk;

    // pulse capture
    always @(posedge clk)
    begin
        if (flash_req)
        begin
            fl_n <= fl_n + 1;
            fl_c <= flash_cmd;
        end
        if (on_chip_data_memory.wr)
        begin
            xr_n <= xr_n + 1;
            xr_c <= on_chip_data_memory;
        end
        if (irq_pending && !irq_deliver)
            irq_lo <= irq_lo + 1;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [33:0] m, input logic [33:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata} & m, e);
    endtask

    task automatic psc(input logic [7:0] d);
        wr(flash_seq_pkg::PSC_ADDR, d, flash_seq_pkg::RESP_OKAY);
    endtask

    task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
        wr(flash_seq_pkg::KEY_ADDR, k1, flash_seq_pkg::RESP_OKAY);
        wr(flash_seq_pkg::KEY_ADDR, k2, flash_seq_pkg::RESP_OKAY);
    endtask

    // movx write, then flash and data-memory pulse counts
    task automatic mv(input logic [15:0] a, input logic [7:0] d, input int nf, input int nx);
        int f0;
        int x0;
        f0 = fl_n;
        x0 = xr_n;
        @(posedge clk);
        cpu.put(a, d);
        repeat (8) @(posedge clk);
        chk(fl_n - f0, nf);
        chk(xr_n - x0, nx);
    endtask

    task automatic t_reset();
        rdc(flash_seq_pkg::PSC_ADDR, '1, 34'h0);
        rdc(flash_seq_pkg::CACHE_ADDR, '1, 34'h0);
        rdc(flash_seq_pkg::STATUS_ADDR, '1, 34'h0);
        rdc(12'h010, '1, {flash_seq_pkg::RESP_SLVERR, 32'h0});
        wr(12'h010, 8'h01, flash_seq_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'he;
        psc(8'h01);
        rdc(flash_seq_pkg::PSC_ADDR, '1, 34'h0);
        s_axi_wstrb <= 4'hf;
    endtask

    task automatic t_on_chip_data_memory();
        psc(8'h02);
        mv(16'h0040, 8'h3c, 0, 1);
        chk(xr_c, {1'b1, 16'h0040, 8'h3c});
    endtask

    task automatic t_prog();
        psc(8'h03);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        mv(16'h0123, 8'hff, 1, 0);
        chk(fl_c[33:16], {flash_seq_pkg::OP_ERASE, 16'h0000});
        psc(8'h01);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        rdc(flash_seq_pkg::STATUS_ADDR, 34'h2, 34'h2);
        mv(16'h0123, 8'h5a, 1, 0);
        chk(fl_c[33:8], {flash_seq_pkg::OP_PROG1, 16'h0123, 8'h5a});
        mv(16'h0124, 8'h11, 0, 0);
        rdc(flash_seq_pkg::STATUS_ADDR, 34'h8, 34'h8);
        wr(flash_seq_pkg::STATUS_ADDR, 8'h08, flash_seq_pkg::RESP_OKAY);
        unlock(flash_seq_pkg::KEY_SECOND, flash_seq_pkg::KEY_FIRST);
        mv(16'h0125, 8'h22, 0, 0);
        unlock(flash_seq_pkg::KEY_FIRST, 8'h00);
        wr(flash_seq_pkg::KEY_ADDR, flash_seq_pkg::KEY_SECOND, flash_seq_pkg::RESP_OKAY);
        mv(16'h0126, 8'h33, 0, 0);
        rdc(flash_seq_pkg::STATUS_ADDR, 34'h8, 34'h8);
        wr(flash_seq_pkg::STATUS_ADDR, 8'h08, flash_seq_pkg::RESP_OKAY);
    endtask

    task automatic t_block();
        psc(8'h00);
        wr(flash_seq_pkg::CACHE_ADDR, 8'h01, flash_seq_pkg::RESP_OKAY);
        psc(8'h01);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        mv(16'h0200, 8'ha1, 0, 0);
        rdc(flash_seq_pkg::STATUS_ADDR, 34'h4, 34'h4);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        mv(16'h0201, 8'hb2, 1, 0);
        chk(fl_c, {flash_seq_pkg::OP_PROG2, 16'h0200, 8'ha1, 8'hb2});
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        mv(16'h0400, 8'hc3, 0, 0);
        psc(8'h00);
        wr(flash_seq_pkg::CACHE_ADDR, 8'h00, flash_seq_pkg::RESP_OKAY);
        rdc(flash_seq_pkg::STATUS_ADDR, 34'h4, 34'h0);
        mv(16'h0401, 8'hd4, 0, 1);
    endtask

    task automatic t_erase();
        psc(8'h03);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        mv(16'h1234, 8'h77, 1, 0);
        chk(fl_c[33:16], {flash_seq_pkg::OP_ERASE, 16'h1200});
    endtask

    task automatic t_irq();
        int i0;
        irq_pending <= 1'b1;
        psc(8'h01);
        unlock(flash_seq_pkg::KEY_FIRST, flash_seq_pkg::KEY_SECOND);
        chk(irq_deliver, 1'b1);
        i0 = irq_lo;
        mv(16'h0500, 8'he5, 1, 0);
        chk(irq_lo != i0, 1'b1);
        chk(irq_deliver, 1'b1);
        irq_pending <= 1'b0;
        psc(8'h00);
        mv(16'h0501, 8'h5e, 0, 1);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_on_chip_data_memory();
        t_prog();
        t_block();
        t_erase();
        t_irq();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule

// *** verilog/flash_byte_write_sequencer.sv ***
// flash write sequencer: unlock keys, byte/pair program, page erase, AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module flash_byte_write_sequencer #(
    parameter int OP_CYCLES = flash_seq_pkg::OP_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [flash_seq_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [flash_seq_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire flash_seq_pkg::movx_wr_s movx,
    output logic movx_ready,
    output flash_seq_pkg::on_chip_data_memory_wr_s on_chip_data_memory,
    output logic flash_req,
    output flash_seq_pkg::flash_cmd_s flash_cmd,
    input wire logic irq_pending,
    output logic irq_deliver
);
    typedef struct packed {
        flash_seq_pkg::key_state_e key;
        logic we;
        logic ee;
        logic blk;
        logic cached;
        logic ignored;
        logic [flash_seq_pkg::FLASH_AW-1:0] cache_addr;
        logic [7:0] cache_data;
        flash_seq_pkg::flash_cmd_s cmd;
        logic flash_req;
        flash_seq_pkg::on_chip_data_memory_wr_s on_chip_data_memory;
        logic movx_ready;
        logic irq_deliver;
        logic aw_held;
        logic [flash_seq_pkg::AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } seq_s;

    seq_s st;
    seq_s next_st;
    logic op_busy;
    logic movx_take;

    function automatic logic [flash_seq_pkg::AXI_AW-1:0] word_of(input logic [flash_seq_pkg::AXI_AW-1:0] a);
        word_of = {a[flash_seq_pkg::AXI_AW-1:2], 2'h0};
    endfunction

    function automatic logic is_mapped(input logic [flash_seq_pkg::AXI_AW-1:0] a);
        logic [flash_seq_pkg::AXI_AW-1:0] w;
        w = word_of(a);
        is_mapped = (w == flash_seq_pkg::PSC_ADDR) || (w == flash_seq_pkg::KEY_ADDR)
            || (w == flash_seq_pkg::CACHE_ADDR) || (w == flash_seq_pkg::STATUS_ADDR);
    endfunction

    // pair commit uses the same timer length as a single byte
    flash_op_timer #(
        .CYCLES(OP_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(st.flash_req),
        .busy(op_busy)
    );

    assign movx_take = movx.valid && st.movx_ready;

    always_comb
    begin
        logic [flash_seq_pkg::AXI_AW-1:0] wa;
        logic [flash_seq_pkg::AXI_AW-1:0] ra;
        logic [31:0] rd;
        wa = word_of(st.aw_addr);
        ra = word_of(s_axi_araddr);
        rd = 32'h0;
        next_st = st;
        next_st.flash_req = 1'b0;
        next_st.on_chip_data_memory.wr = 1'b0;

        // a cached byte is dropped, never programmed, once either enable goes
        if (!st.we || !st.blk)
            next_st.cached = 1'b0;

        // axi write channels, taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        if (st.aw_held && st.w_held && !st.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = is_mapped(st.aw_addr) ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
            if (st.w_lane0)
            begin
                if (wa == flash_seq_pkg::PSC_ADDR)
                begin
                    next_st.we = st.w_data[flash_seq_pkg::PSC_WE_BIT];
                    next_st.ee = st.w_data[flash_seq_pkg::PSC_EE_BIT];
                end
                else if (wa == flash_seq_pkg::CACHE_ADDR)
                begin
                    next_st.blk = st.w_data[flash_seq_pkg::CACHE_BLK_BIT];
                end
                else if (wa == flash_seq_pkg::STATUS_ADDR)
                begin
                    if (st.w_data[flash_seq_pkg::ST_IGNORED_BIT])
                        next_st.ignored = 1'b0;
                end
                else if (wa == flash_seq_pkg::KEY_ADDR)
                begin
                    // any key out of place relocks
                    if (st.key == flash_seq_pkg::KEY_LOCKED && st.w_data == flash_seq_pkg::KEY_FIRST)
                        next_st.key = flash_seq_pkg::KEY_HALF;
                    else if (st.key == flash_seq_pkg::KEY_HALF && st.w_data == flash_seq_pkg::KEY_SECOND)
                        next_st.key = flash_seq_pkg::KEY_OPEN;
                    else
                        next_st.key = flash_seq_pkg::KEY_LOCKED;
                end
            end
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;

        // axi read: one cycle after the address is taken
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && st.arready)
        begin
            if (ra == flash_seq_pkg::PSC_ADDR)
            begin
                rd[flash_seq_pkg::PSC_WE_BIT] = st.we;
                rd[flash_seq_pkg::PSC_EE_BIT] = st.ee;
            end
            else if (ra == flash_seq_pkg::CACHE_ADDR)
            begin
                rd[flash_seq_pkg::CACHE_BLK_BIT] = st.blk;
            end
            else if (ra == flash_seq_pkg::STATUS_ADDR)
            begin
                rd[flash_seq_pkg::ST_BUSY_BIT] = op_busy || st.flash_req;
                rd[flash_seq_pkg::ST_OPEN_BIT] = (st.key == flash_seq_pkg::KEY_OPEN);
                rd[flash_seq_pkg::ST_CACHED_BIT] = st.cached;
                rd[flash_seq_pkg::ST_IGNORED_BIT] = st.ignored;
            end
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = is_mapped(s_axi_araddr) ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;

        // MOVX write: routed by the write enable; a flash write consumes the unlock
        if (movx_take)
        begin
            if (!st.we)
            begin
                next_st.on_chip_data_memory.wr = 1'b1;
                next_st.on_chip_data_memory.addr = movx.addr;
                next_st.on_chip_data_memory.data = movx.data;
            end
            else if (st.key != flash_seq_pkg::KEY_OPEN)
            begin
                next_st.ignored = 1'b1;
                next_st.key = flash_seq_pkg::KEY_LOCKED;
            end
            else
            begin
                next_st.key = flash_seq_pkg::KEY_LOCKED;
                next_st.cmd.addr = movx.addr;
                next_st.cmd.data_lo = movx.data;
                next_st.cmd.data_hi = 8'hff;
                if (st.ee)
                begin
                    next_st.flash_req = 1'b1;
                    next_st.cmd.op = flash_seq_pkg::OP_ERASE;
                    next_st.cmd.addr[flash_seq_pkg::PAGE_LSB-1:0] = '0;
                end
                else if (st.blk)
                begin
                    if (st.cached && movx.addr == flash_seq_pkg::FLASH_AW'(st.cache_addr + 1'b1))
                    begin
                        next_st.flash_req = 1'b1;
                        next_st.cached = 1'b0;
                        next_st.cmd.op = flash_seq_pkg::OP_PROG2;
                        next_st.cmd.addr = st.cache_addr;
                        next_st.cmd.data_lo = st.cache_data;
                        next_st.cmd.data_hi = movx.data;
                    end
                    else
                    begin
                        next_st.cached = 1'b1;
                        next_st.cache_addr = movx.addr;
                        next_st.cache_data = movx.data;
                    end
                end
                else
                begin
                    next_st.flash_req = 1'b1;
                    next_st.cmd.op = flash_seq_pkg::OP_PROG1;
                end
            end
        end

        next_st.movx_ready = !next_st.flash_req && !st.flash_req && !op_busy;
        // interrupts wait until no flash operation is pending or running
        next_st.irq_deliver = irq_pending && !op_busy && !st.flash_req && !next_st.flash_req;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign movx_ready = st.movx_ready;
    assign on_chip_data_memory = st.on_chip_data_memory;
    assign flash_req = st.flash_req;
    assign flash_cmd = st.cmd;
    assign irq_deliver = st.irq_deliver;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_prog_needs_unlock: assert property (
        st.flash_req && st.cmd.op != flash_seq_pkg::OP_ERASE
        |-> $past(st.key) == flash_seq_pkg::KEY_OPEN && $past(st.we) && !$past(st.ee))
        else $error("program issued without open unlock");

    a_erase_both_enables: assert property (
        st.flash_req && st.cmd.op == flash_seq_pkg::OP_ERASE
        |-> $past(st.we) && $past(st.ee) && st.cmd.addr[flash_seq_pkg::PAGE_LSB-1:0] == '0)
        else $error("erase without both enables or unaligned page");

    a_relock_after_write: assert property (
        movx_take && st.we |=> st.key == flash_seq_pkg::KEY_LOCKED)
        else $error("unlock survived a flash write");

    a_pair_from_cache: assert property (
        st.flash_req && st.cmd.op == flash_seq_pkg::OP_PROG2
        |-> $past(st.cached) && st.cmd.addr == $past(st.cache_addr) && st.cmd.data_lo == $past(st.cache_data))
        else $error("pair commit without matching cached byte");

    a_first_byte_held: assert property (
        movx_take && st.we && st.blk && !st.ee && st.key == flash_seq_pkg::KEY_OPEN && !st.cached
        |=> !st.flash_req && st.cached ##1 !st.flash_req)
        else $error("first block byte programmed alone");

    a_cache_dropped: assert property (
        !st.we |=> !st.cached)
        else $error("cache kept after write enable cleared");

    a_bad_key_void: assert property (
        movx_take && st.we && st.key != flash_seq_pkg::KEY_OPEN |=> !st.flash_req && st.ignored && !st.on_chip_data_memory.wr)
        else $error("locked flash write not voided");

    a_key_two_step: assert property (
        $rose(st.key == flash_seq_pkg::KEY_OPEN) |-> $past(st.key) == flash_seq_pkg::KEY_HALF)
        else $error("unlock opened without first key");

    a_data_route: assert property (
        movx_take && !st.we |=> st.on_chip_data_memory.wr && !st.flash_req && st.on_chip_data_memory.addr == $past(movx.addr))
        else $error("data write not routed to data memory");

    a_irq_held: assert property (
        op_busy || st.flash_req |-> !st.irq_deliver)
        else $error("interrupt delivered during flash operation");

    c_single_prog: cover property (st.flash_req && st.cmd.op == flash_seq_pkg::OP_PROG1);
    c_pair_prog: cover property (st.flash_req && st.cmd.op == flash_seq_pkg::OP_PROG2);
    c_page_erase: cover property (st.flash_req && st.cmd.op == flash_seq_pkg::OP_ERASE);
    c_irq_after_op: cover property ($fell(op_busy) ##[1:3] st.irq_deliver);
endmodule

// *** verilog/flash_op_timer.sv ***
// busy timer for one flash program or erase operation
`timescale 1ns/1ps
module flash_op_timer #(
    parameter int CYCLES = flash_seq_pkg::OP_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] count;
    } timer_s;

    timer_s st;
    timer_s next_st;

    always_comb
    begin
        next_st = st;
        if (st.busy)
        begin
            if (st.count == '0)
                next_st.busy = 1'b0;
            else
                next_st.count = CW'(st.count - 1'b1);
        end
        else if (start)
        begin
            next_st.busy = 1'b1;
            next_st.count = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign busy = st.busy;
endmodule

// *** verilog/flash_seq_pkg.sv ***
// constants, types and state carriers for the flash byte write sequencer
package flash_seq_pkg;
    localparam int AXI_AW = 12;
    localparam int FLASH_AW = 16;
    // register index as printed; byte address is four times it
    localparam logic [7:0] PSC_INDEX = 8'h8f;
    localparam logic [AXI_AW-1:0] PSC_ADDR = {2'h0, PSC_INDEX, 2'h0};
    localparam logic [AXI_AW-1:0] KEY_ADDR = 12'h000;
    localparam logic [AXI_AW-1:0] CACHE_ADDR = 12'h004;
    localparam logic [AXI_AW-1:0] STATUS_ADDR = 12'h008;
    localparam int PSC_WE_BIT = 0;
    localparam int PSC_EE_BIT = 1;
    localparam int CACHE_BLK_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OPEN_BIT = 1;
    localparam int ST_CACHED_BIT = 2;
    localparam int ST_IGNORED_BIT = 3;
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam int PAGE_LSB = 9;
    localparam int OP_CYCLES = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_state_e;
    typedef enum logic [1:0] {OP_PROG1, OP_PROG2, OP_ERASE} flash_op_e;

    typedef struct packed {
        flash_op_e op;
        logic [FLASH_AW-1:0] addr;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
    } flash_cmd_s;

    typedef struct packed {
        logic valid;
        logic [FLASH_AW-1:0] addr;
        logic [7:0] data;
    } movx_wr_s;

    typedef struct packed {
        logic wr;
        logic [FLASH_AW-1:0] addr;
        logic [7:0] data;
    } on_chip_data_memory_wr_s;
endpackage
